// *** sdtc_device.sv ***
`include "sdtc_defines.svh"

module sdtc_device
    import sdtc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [1:0] i_ba,
    input wire logic [11:0] i_addr,
    input wire logic [3:0] i_dqm,
    input wire logic [31:0] i_dq,
    output logic [31:0] o_dq,
    output logic [3:0] o_dq_oe,
    output logic o_suspended,
    output logic [3:0] o_bank_open,
    output logic o_wbuf_ready,
    output logic o_wbuf_overrun
);
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [3:0] burst_mask(input logic [2:0] code);
        case (code)
            3'h0: return 4'h0;
            3'h1: return 4'h1;
            3'h2: return 4'h3;
            default: return 4'h7;
        endcase
    endfunction : burst_mask

    // sequential order wraps inside the aligned burst block
    function automatic logic [3:0] next_col(input logic [3:0] col, input logic [3:0] msk);
        logic [3:0] inc;
        inc = col + 4'h1;
        return (col & ~msk) | (inc & msk);
    endfunction : next_col

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic cke_r;
    logic [2:0] cl_r;
    logic [2:0] blc_r;
    logic [3:0] bank_open_r;
    sdtc_burst_t burst_r;
    sdtc_burst_t burst_nxt;
    logic [3:0] col_r;
    logic [1:0] bank_r;
    logic [2:0] left_r;
    logic [2:0] rd_vld_r;
    logic [31:0] rd_data_r [3];
    logic [3:0] dqm_d1_r;
    logic [3:0] dqm_d2_r;
    logic [31:0] mem_r [`SDTC_MEM_WORDS];
    logic overrun_r;

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    logic run;
    sdtc_cmd_t cmd;
    logic [3:0] bl_mask;
    logic is_col;
    logic close_hit;
    logic stop;
    logic cont;
    logic rd_issue;
    logic wr_take;
    logic [5:0] cur_idx;
    logic [1:0] sel;

    // an edge acts only if clock-enable was high one edge earlier
    assign run = cke_r;
    assign cmd = sdtc_decode({i_cs_n, i_ras_n, i_cas_n, i_we_n});
    assign bl_mask = burst_mask(blc_r);
    assign is_col = run && (cmd == cmd_read || cmd == cmd_write);
    assign close_hit = run && cmd == cmd_close && (i_addr[`SDTC_ALLBANK_BIT] || i_ba == bank_r);
    // a new column command, a stop or closing the bank cuts the burst short
    assign stop = is_col || (run && cmd == cmd_stop) || close_hit;
    assign cont = run && !stop && left_r != 3'h0;
    assign rd_issue = (run && cmd == cmd_read) || (burst_r == burst_read && cont);
    assign wr_take = (run && cmd == cmd_write) || (burst_r == burst_write && cont);
    assign cur_idx = is_col ? {i_ba, i_addr[`SDTC_COL_MSB:0]} : {bank_r, col_r};
    assign sel = (cl_r == 3'h1) ? 2'h0 : ((cl_r == 3'h2) ? 2'h1 : 2'h2);

    // ------------------------------------------------------------------------
    // burst sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        burst_nxt = burst_r;
        if (is_col) begin
            burst_nxt = (cmd == cmd_read) ? burst_read : burst_write;
        end else begin
            case (burst_r)
                burst_idle: burst_nxt = burst_idle;
                burst_read, burst_write: begin
                    if (run && (stop || left_r == 3'h0)) begin
                        burst_nxt = burst_idle;
                    end
                end
                default: burst_nxt = burst_idle;
            endcase
        end
    end

    // every state update waits on run, so a suspend freezes the burst
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            burst_r <= burst_idle;
            left_r <= 3'h0;
            col_r <= 4'h0;
            bank_r <= 2'h0;
        end else if (run) begin
            burst_r <= burst_nxt;
            if (is_col) begin
                bank_r <= i_ba;
                left_r <= bl_mask[2:0];
                col_r <= next_col(i_addr[`SDTC_COL_MSB:0], bl_mask);
            end else if (cont) begin
                left_r <= left_r - 3'h1;
                col_r <= next_col(col_r, bl_mask);
            end
        end
    end

    // ------------------------------------------------------------------------
    // clock-enable, mode word and open banks
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cke_r <= 1'b1;
        end else begin
            cke_r <= i_cke;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cl_r <= `SDTC_CL_RST;
            blc_r <= `SDTC_BL_RST;
            bank_open_r <= 4'h0;
        end else if (run) begin
            if (cmd == cmd_mode_load) begin
                cl_r <= i_addr[`SDTC_MR_CL_MSB:`SDTC_MR_CL_LSB];
                blc_r <= i_addr[`SDTC_MR_BL_MSB:`SDTC_MR_BL_LSB];
            end else if (cmd == cmd_activate) begin
                bank_open_r[i_ba] <= 1'b1;
            end else if (cmd == cmd_close) begin
                if (i_addr[`SDTC_ALLBANK_BIT]) begin
                    bank_open_r <= 4'h0;
                end else begin
                    bank_open_r[i_ba] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // read pipeline: stage n carries words read n+1 edges ago
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rd_vld_r <= 3'h0;
        end else if (run) begin
            rd_vld_r <= {rd_vld_r[1:0], rd_issue};
        end
    end

    always_ff @(posedge i_clock) begin
        if (run) begin
            rd_data_r[0] <= mem_r[cur_idx];
            rd_data_r[1] <= rd_data_r[0];
            rd_data_r[2] <= rd_data_r[1];
        end
    end

    // mask delay line runs free of suspend, as the mask pin is not clock gated
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            dqm_d1_r <= 4'hF;
            dqm_d2_r <= 4'hF;
        end else begin
            dqm_d1_r <= i_dqm;
            dqm_d2_r <= dqm_d1_r;
        end
    end

    assign o_dq = rd_data_r[sel];
    assign o_dq_oe = {4{rd_vld_r[sel]}} & ~dqm_d2_r;

    // ------------------------------------------------------------------------
    // write path through the buffer into storage
    // ------------------------------------------------------------------------
    logic push_ready;
    logic [`SDTC_WBUF_W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [`SDTC_WBUF_W-1:0] pop_data;
    logic [5:0] pop_idx;

    // a masked lane is stored with its byte enable low
    assign push_data = {~i_dqm, cur_idx, i_dq};
    // storage has one port; a read issue stalls the drain so the buffer can fill
    assign pop_ready = run && !rd_issue;
    assign pop_idx = pop_data[`SDTC_WB_IDX_MSB:`SDTC_WB_IDX_LSB];

    sdtc_fifo #(
        .WIDTH(`SDTC_WBUF_W),
        .DEPTH(`SDTC_WBUF_DEPTH)
    ) u_wbuf (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_valid(wr_take),
        .o_ready(push_ready),
        .i_data(push_data),
        .o_valid(pop_valid),
        .i_ready(pop_ready),
        .o_data(pop_data)
    );

    always_ff @(posedge i_clock) begin
        if (pop_valid && pop_ready) begin
            for (int b = 0; b < 4; b++) begin
                if (pop_data[`SDTC_WB_BE_LSB + b]) begin
                    mem_r[pop_idx][8*b +: 8] <= pop_data[8*b +: 8];
                end
            end
        end
    end

    // a word the controller offers while the buffer is full is lost
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            overrun_r <= 1'b0;
        end else if (wr_take && !push_ready) begin
            overrun_r <= 1'b1;
        end
    end

    assign o_suspended = !cke_r;
    assign o_bank_open = bank_open_r;
    assign o_wbuf_ready = push_ready;
    assign o_wbuf_overrun = overrun_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_col_each_cycle: assert property (@(posedge i_clock) disable iff (i_rst)
        is_col |=> (burst_r != burst_idle) && (bank_r == $past(i_ba)))
        else $error("column command not taken");
    a_suspend_entry: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_cke |-> ##2 ($stable(left_r) && $stable(rd_vld_r) && $stable(col_r)))
        else $error("state moved during suspend");
    a_resume_exit: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_cke && !run) |=> run && !o_suspended)
        else $error("clock not resumed after one edge");
    a_write_mask_now: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_take |-> (push_data[`SDTC_WB_BE_MSB:`SDTC_WB_BE_LSB] == ~i_dqm))
        else $error("write mask not applied on same edge");
    a_read_mask_float: assert property (@(posedge i_clock) disable iff (i_rst)
        $past(rd_vld_r[sel]) |-> ((o_dq_oe & $past(i_dqm, 2)) == 4'h0))
        else $error("masked read lane still driven");
    a_write_first_word: assert property (@(posedge i_clock) disable iff (i_rst)
        (run && cmd == cmd_write) |-> wr_take && (push_data[`SDTC_WB_DATA_MSB:0] == i_dq))
        else $error("first write word not taken with command");
    a_close_float: assert property (@(posedge i_clock) disable iff (i_rst)
        (close_hit && burst_r == burst_read) ##1 (run && !is_col)[*3] |=> (o_dq_oe == 4'h0))
        else $error("output still driven after close");
endmodule : sdtc_device

// *** sdtc_defines.svh ***
// Operation
// - a column read or write is accepted on every clock, back to back.
// - clock-enable sampled low suspends internal clocking from the next edge.
// - clock-enable sampled high resumes internal clocking from the next edge.
// - write mask acts at once; a masked byte on that edge is not stored.
// - read mask floats the matching output byte lanes two clocks after sampling.
// - the first write word is captured on the write command edge itself.
// - closing a bank during a read floats output after read latency clocks.
`ifndef SDTC_DEFINES_SVH
`define SDTC_DEFINES_SVH

// ----------------------------------------------------------------------------
// mode word layout and reset values
// ----------------------------------------------------------------------------
`define SDTC_MR_BL_MSB 2
`define SDTC_MR_BL_LSB 0
`define SDTC_MR_CL_MSB 6
`define SDTC_MR_CL_LSB 4
`define SDTC_CL_RST 3'h2
`define SDTC_BL_RST 3'h0
`define SDTC_ALLBANK_BIT 10

// ----------------------------------------------------------------------------
// storage and buffer geometry
// ----------------------------------------------------------------------------
`define SDTC_COL_MSB 3
`define SDTC_MEM_WORDS 64
`define SDTC_WBUF_DEPTH 8
`define SDTC_WBUF_W 42
`define SDTC_WB_BE_MSB 41
`define SDTC_WB_BE_LSB 38
`define SDTC_WB_IDX_MSB 37
`define SDTC_WB_IDX_LSB 32
`define SDTC_WB_DATA_MSB 31

// ----------------------------------------------------------------------------
// fixed cycle latencies
// ----------------------------------------------------------------------------
`define SDTC_READ_MASK_CYC 2
`define SDTC_COL_GAP_CYC 1

`endif

// *** sdtc_pkg.sv ***
package sdtc_pkg;

    // ------------------------------------------------------------------------
    // command and burst types
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        cmd_inhibit, cmd_nop, cmd_activate, cmd_read, cmd_write,
        cmd_close, cmd_refresh, cmd_mode_load, cmd_stop
    } sdtc_cmd_t;

    typedef enum logic [1:0] {burst_idle, burst_read, burst_write} sdtc_burst_t;

    // decode of the four command strobes, select first
    function automatic sdtc_cmd_t sdtc_decode(input logic [3:0] pins);
        sdtc_cmd_t c;
        c = cmd_nop;
        if (pins[3]) begin
            c = cmd_inhibit;
        end else begin
            case (pins[2:0])
                3'h3: c = cmd_activate;
                3'h5: c = cmd_read;
                3'h4: c = cmd_write;
                3'h2: c = cmd_close;
                3'h1: c = cmd_refresh;
                3'h0: c = cmd_mode_load;
                3'h6: c = cmd_stop;
                default: c = cmd_nop;
            endcase
        end
        return c;
    endfunction : sdtc_decode

endpackage : sdtc_pkg

// *** sdtc_fifo.sv ***
// ----------------------------------------------------------------------------
// write data buffer, depth must be a power of two
// ----------------------------------------------------------------------------
module sdtc_fifo #(
    parameter int WIDTH = 42,
    parameter int DEPTH = 8
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty without a counter
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign push = i_valid && !full;
    assign pop = i_ready && !empty;
    assign o_data = store_r[rd_ptr_r[AW-1:0]];

    // pointer update
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // storage has no reset, only valid entries are ever read
    always_ff @(posedge i_clock) begin
        if (push) begin
            store_r[wr_ptr_r[AW-1:0]] <= i_data;
        end
    end
endmodule : sdtc_fifo

// *** sdtc_ctrl_model.sv ***
// ----------------------------------------------------------------------------
// controller model: one command per falling edge, spacing kept per bank
// ----------------------------------------------------------------------------
module sdtc_ctrl_model (
    input wire logic i_clock,
    input wire logic i_wbuf_ready,
    output logic o_cke,
    output logic [3:0] o_cmd,
    output logic [1:0] o_ba,
    output logic [11:0] o_addr,
    output logic [3:0] o_dqm,
    output logic [31:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ns minimums as whole 20 ns clocks, rounded up, slower grade
    localparam int CK = 20;
    localparam int RAS_C = (42 + CK - 1) / CK;
    localparam int RC_C = (70 + CK - 1) / CK;
    localparam int RCD_C = (20 + CK - 1) / CK;
    localparam int RRD_C = (14 + CK - 1) / CK;
    localparam int XSR_C = (70 + CK - 1) / CK < 2 ? 2 : (70 + CK - 1) / CK;
    localparam int RFC_C = (70 + CK - 1) / CK;
    localparam int PAUSE_C = 50; // power-up pause, shortened so the run stays short
    // step count and history; rows stay open far below the upper limit here
    int now = 100;
    int act_at [4] = '{0, 0, 0, 0};
    int act_any = 0;
    int mode_at = 0;
    int wr_at = 0;
    int xsr_at = 0; // self refresh is never entered, so its exit wait is met
    // idle pins at time zero
    initial begin
        o_cke = 1'b1;
        o_cmd = 4'h8;
        o_ba = 2'h0;
        o_addr = 12'h000;
        o_dqm = 4'h0;
        o_dq = 32'h0;
    end
    // data lines flip when not carrying write data, so no stale word is seen
    task automatic step(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                        input logic [3:0] m, input logic [31:0] d, input bit wd);
        @(negedge i_clock);
        o_cmd = c;
        o_ba = b;
        o_addr = a;
        o_dqm = m;
        o_dq = wd ? d : ~o_dq;
        if (wd) wr_at = now;
        if (c == 4'h3) begin
            act_at[b] = now;
            act_any = now;
        end
        if (c == 4'h0) mode_at = now;
        now++;
    endtask : step
    task automatic nop(input int n);
        repeat (n) step(4'h7, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
    endtask : nop
    // activate only once every gap has run out
    task automatic activate(input logic [1:0] b);
        while (now - act_at[b] < RC_C || now - act_any < RRD_C
               || now - mode_at < 2 || now - xsr_at < XSR_C || now - wr_at < 5)
            nop(1);
        step(4'h3, b, 12'h000, 4'h0, 32'h0, 1'b0);
    endtask : activate
    task automatic close(input logic [1:0] b, input logic all);
        while (now - act_at[b] < RAS_C || now - wr_at < 2) nop(1);
        step(4'h2, b, {1'b0, all, 10'h000}, 4'h0, 32'h0, 1'b0);
    endtask : close
    // writes also wait for buffer room; columns may come every clock
    task automatic column(input logic [3:0] c, input logic [1:0] b, input logic [3:0] col,
                          input logic [3:0] m, input logic [31:0] d);
        while (now - act_at[b] < RCD_C || (c == 4'h4 && i_wbuf_ready !== 1'b1)) nop(1);
        step(c, b, {8'h00, col}, m, d, c == 4'h4);
    endtask : column
    task automatic mode(input logic [2:0] cl, input logic [2:0] bl);
        step(4'h0, 2'h0, {5'h00, cl, 1'b0, bl}, 4'h0, 32'h0, 1'b0);
        nop(2);
    endtask : mode
    // clock-enable moves only where the caller already stands on a falling edge
    task automatic set_cke(input logic v);
        o_cke = v;
    endtask : set_cke
    // the run is far shorter than one full refresh interval
    task automatic power_up();
        nop(PAUSE_C);
        repeat (2) begin
            step(4'h1, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
            nop(RFC_C);
        end
    endtask : power_up
endmodule : sdtc_ctrl_model

// *** sdtc_device_test.sv ***
// ----------------------------------------------------------------------------
// self-checking bench for the command timing block
// ----------------------------------------------------------------------------
module sdtc_device_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    wire logic cke;
    wire logic [3:0] cmd;
    wire logic [1:0] ba;
    wire logic [11:0] addr;
    wire logic [3:0] dqm;
    wire logic [31:0] dq_in;
    logic [31:0] dq_out;
    logic [3:0] oe;
    logic [3:0] bank_open;
    logic susp;
    logic wb_ready;
    logic wb_over;
    logic [31:0] exp_mem [64];
    logic [31:0] seed = 32'h0000002D;
    int bad_count = 0;
    int total_checks = 0;
    int cur_cl = 2;
    int cur_bl = 1;
    // 50 MHz clock
    always #10 i_clock = ~i_clock;
    sdtc_device i_sdtc_device (
        .i_clock(i_clock), .i_rst(i_rst), .i_cke(cke), .i_cs_n(cmd[3]), .i_ras_n(cmd[2]),
        .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba), .i_addr(addr), .i_dqm(dqm), .i_dq(dq_in),
        .o_dq(dq_out), .o_dq_oe(oe), .o_suspended(susp), .o_bank_open(bank_open),
        .o_wbuf_ready(wb_ready), .o_wbuf_overrun(wb_over)
    );
    sdtc_ctrl_model m (
        .i_clock(i_clock), .i_wbuf_ready(wb_ready), .o_cke(cke), .o_cmd(cmd), .o_ba(ba),
        .o_addr(addr), .o_dqm(dqm), .o_dq(dq_in)
    );
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    function automatic logic [31:0] lanes(input logic [3:0] e);
        return {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
    endfunction : lanes
    // burst columns wrap inside the aligned block of the burst length
    function automatic logic [5:0] word_idx(input logic [1:0] b, input logic [3:0] c,
                                            input int bl, input int i);
        logic [3:0] k;
        k = 4'(bl - 1);
        return {b, (c & ~k) | ((c + 4'(i)) & k)};
    endfunction : word_idx
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bits
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic mode_set(input logic [2:0] cl, input logic [2:0] blc);
        m.mode(cl, blc);
        cur_cl = int'(cl);
        cur_bl = 1 << blc;
    endtask : mode_set
    // all words of a burst share the mask; masked bytes keep their old value
    task automatic wr_burst(input logic [1:0] b, input logic [3:0] c, input logic [3:0] k);
        logic [31:0] d;
        logic [5:0] ix;
        for (int i = 0; i < cur_bl; i++) begin
            d = rnd();
            ix = word_idx(b, c, cur_bl, i);
            exp_mem[ix] = (exp_mem[ix] & lanes(k)) | (d & ~lanes(k));
            if (i == 0) m.column(4'h4, b, c, k, d);
            else m.step(4'h7, 2'h0, 12'h000, k, d, 1'b1);
        end
    endtask : wr_burst
    // n back-to-back read bursts; a mask given with the first read floats lanes
    task automatic rd_seq(input logic [1:0] b, input logic [3:0] c, input int n,
                          input logic [3:0] k);
        int w;
        logic [3:0] e;
        logic [5:0] ix;
        for (int s = 0; s <= n * cur_bl + cur_cl; s++) begin
            if (s < n * cur_bl && s % cur_bl == 0)
                m.column(4'h5, b, c + 4'(s / cur_bl), s == 0 ? k : 4'h0, 32'h0);
            else
                m.nop(1);
            w = s - cur_cl;
            e = (w == 2 - cur_cl) ? ~k : 4'hF;
            if (w >= 0 && w < n * cur_bl) begin
                ix = word_idx(b, c + 4'(w / cur_bl), cur_bl, w % cur_bl);
                chk_bits(oe, e);
                chk_word(dq_out & lanes(e), exp_mem[ix] & lanes(e));
            end else if (w == n * cur_bl) chk_bits(oe, 4'h0);
        end
    endtask : rd_seq
    // an all-bank close two clocks into a long read
    task automatic rd_close(input logic [1:0] b);
        m.activate(b);
        m.nop(4);
        m.column(4'h5, b, 4'h0, 4'h0, 32'h0);
        m.nop(1);
        for (int s = 2; s <= cur_cl + 2; s++) begin
            if (s == 2) m.close(b, 1'b1);
            else m.nop(1);
            if (s == cur_cl + 1) chk_bits(oe, 4'hF);
        end
        chk_bits(oe, 4'h0);
        chk_bits(bank_open, 4'h0);
    endtask : rd_close
    // a burst stop one clock after the second word leaves the rest unwritten
    task automatic wr_stop(input logic [1:0] b, input logic [3:0] c);
        logic [31:0] d;
        logic [5:0] ix;
        for (int i = 0; i < 2; i++) begin
            d = rnd();
            ix = word_idx(b, c, cur_bl, i);
            exp_mem[ix] = d;
            if (i == 0) m.column(4'h4, b, c, 4'h0, d);
            else m.step(4'h7, 2'h0, 12'h000, 4'h0, d, 1'b1);
        end
        m.step(4'h6, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
        m.nop(8);
        rd_seq(b, c, 1, 4'h0);
    endtask : wr_stop
    // main sequence
    initial begin
        logic [1:0] lb;
        logic [3:0] lc;
        repeat (20) @(negedge i_clock);
        i_rst = 1'b0;
        chk_bits({susp, wb_over, 1'b0, wb_ready}, 4'h1);
        chk_bits(oe | bank_open, 4'h0);
        m.power_up();
        for (int b = 0; b < 4; b++) m.activate(2'(b));
        m.nop(1);
        chk_bits(bank_open, 4'hF);
        mode_set(3'h2, 3'h3);
        for (int j = 0; j < 8; j++) wr_burst(2'(j / 2), 4'(j * 8), 4'h0);
        mode_set(3'h2, 3'h0);
        repeat (8) begin
            lb = 2'(rnd());
            lc = 4'(rnd());
            wr_burst(lb, lc, 4'(rnd()));
        end
        m.nop(12);
        rd_seq(lb, lc, 1, 4'h0);
        mode_set(3'h2, 3'h2);
        wr_stop(2'(rnd()), 4'(rnd()));
        // suspend in mid burst, so the frozen edges have a burst to hold still
        m.column(4'h5, 2'h1, 4'h0, 4'h0, 32'h0);
        m.set_cke(1'b0);
        m.nop(2);
        m.set_cke(1'b1);
        m.nop(8);
        for (int cl = 1; cl < 4; cl++) begin
            for (int bc = 0; bc < 4; bc++) begin
                mode_set(3'(cl), 3'(bc));
                rd_seq(2'(rnd()), 4'(rnd()), 3, 4'(rnd()));
            end
            mode_set(3'(cl), 3'h3);
            rd_close(2'(rnd()));
        end
        mode_set(3'h2, 3'h0);
        m.set_cke(1'b0);
        m.nop(1);
        chk_bits({3'h0, susp}, 4'h1);
        m.step(4'h4, 2'h0, 12'h005, 4'h0, ~exp_mem[5], 1'b1);
        chk_bits({3'h0, susp}, 4'h1);
        m.set_cke(1'b1);
        m.nop(1);
        chk_bits({3'h0, susp}, 4'h0);
        rd_seq(2'h0, 4'h5, 1, 4'h0);
        m.nop(12);
        chk_bits({2'h0, wb_over, wb_ready}, 4'h1);
        stop_test();
    end
    // watchdog: the sequence needs about 500 clocks
    initial begin
        repeat (20000) @(posedge i_clock);
        bad_count++;
        stop_test();
    end
endmodule : sdtc_device_test
